// [dv/ebs_ext_dev.sv]
`timescale 1ns/1ps
`default_nettype none
module ebs_ext_dev
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	// selects and commanded stall length
	input wire logic [7:0] i_bank_select_n,
	input wire logic [1:0] i_io_device_select_n,
	input wire logic [3:0] i_wait_len,
	// stall back to the controller
	output logic o_bus_wait_n
);
	logic [3:0] cnt_r;
	logic sel;
	assign sel = !(&i_bank_select_n && &i_io_device_select_n);
	// cycles since selected, saturating so a long cycle cannot wrap
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			cnt_r <= 4'h0;
		else if (!sel)
			cnt_r <= 4'h0;
		else if (cnt_r != 4'hf)
			cnt_r <= cnt_r + 4'h1;
	end
	// stall the first i_wait_len selected cycles only
	assign o_bus_wait_n = !(sel && cnt_r < i_wait_len);
endmodule : ebs_ext_dev
`default_nettype wire

// [dv/ebs_strobe_gen_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ebs_params.svh"
module ebs_strobe_gen_asserts
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	// watched pins
	input wire logic i_bus_wait_n,
	input wire logic o_req_ready,
	input wire logic o_done,
	input wire logic o_miss,
	input wire logic [`EBS_NUM_BANKS-1:0] o_bank_select_n,
	input wire logic [`EBS_NUM_IO-1:0] o_io_device_select_n,
	input wire logic o_read_strobe_n,
	input wire logic o_write_strobe_n,
	input wire logic [1:0] o_byte_write_strobe_n
);
	// any select low marks a bus cycle in flight
	wire logic act;
	assign act = (o_bank_select_n != `EBS_BANK_SEL_IDLE) ||
		(o_io_device_select_n != `EBS_IO_SEL_IDLE);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	idle_pins_a: assert property (o_req_ready |-> !act && o_read_strobe_n && o_write_strobe_n
		&& o_byte_write_strobe_n == `EBS_LANES_IDLE) else $error("pins active while idle");
	one_bank_a: assert property ($onehot0(~o_bank_select_n)) else $error("two banks selected");
	miss_quiet_a: assert property (o_miss |-> o_done && !act) else $error("miss drove a select");
	io_alone_a: assert property (o_io_device_select_n != `EBS_IO_SEL_IDLE |->
		o_bank_select_n == `EBS_BANK_SEL_IDLE && o_io_device_select_n != 2'h0) else $error("io select clash");
	read_only_a: assert property (!o_read_strobe_n |-> o_write_strobe_n && act) else $error("read strobe bad");
	write_lanes_a: assert property (!o_write_strobe_n |-> act
		&& o_byte_write_strobe_n != `EBS_LANES_IDLE) else $error("write without byte lane");
	wait_hold_a: assert property (act && !i_bus_wait_n |=> !o_done) else $error("done despite wait");
	done_release_a: assert property (o_done |-> !act ##1 (o_req_ready && !o_done)) else $error("done pulse bad");
	end_done_a: assert property (act ##1 !act |-> o_done) else $error("select rose without done");
endmodule : ebs_strobe_gen_asserts
bind ebs_strobe_gen ebs_strobe_gen_asserts i_ebs_strobe_gen_asserts (.i_mclk, .i_sys_rst, .i_bus_wait_n,
	.o_req_ready, .o_done, .o_miss, .o_bank_select_n, .o_io_device_select_n, .o_read_strobe_n,
	.o_write_strobe_n, .o_byte_write_strobe_n);
`default_nettype wire

// [dv/ebs_strobe_gen_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ebs_params.svh"
module ebs_strobe_gen_tb;
	import ebs_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	ebs_bank_cfg_s [7:0] cfg;
	logic [3:0] wlen = 4'h0;
	logic vld = 1'b0;
	ebs_req_s req = '0;
	logic rdy, done, miss, w16, wait_n, rd_n, wr_n;
	logic [7:0] sel_n;
	logic [1:0] io_n, be_n;
	logic [23:0] addr_q;
	int num_errors = 0;
	int tests_run = 0;
	always #25 mclk = ~mclk;
	ebs_strobe_gen i_ebs_strobe_gen (.i_mclk(mclk), .i_sys_rst(rst), .i_bank_config(cfg),
		.i_io_cycles(4'h3), .i_req_valid(vld), .i_req(req), .o_req_ready(rdy), .o_done(done),
		.o_miss(miss), .o_bus_width16(w16), .i_bus_wait_n(wait_n), .o_addr(addr_q),
		.o_bank_select_n(sel_n), .o_io_device_select_n(io_n), .o_read_strobe_n(rd_n),
		.o_write_strobe_n(wr_n), .o_byte_write_strobe_n(be_n));
	ebs_ext_dev i_ebs_ext_dev (.i_mclk(mclk), .i_sys_rst(rst), .i_bank_select_n(sel_n),
		.i_io_device_select_n(io_n), .i_wait_len(wlen), .o_bus_wait_n(wait_n));
	////////////////////////////////////////////////////////////////
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task end_sim;
		if (num_errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	// one access: pins seen in the first strobe cycle, then edges until done
	task acc(input logic [23:0] a, input logic w, input logic s16, input ebs_kind_e k,
		input logic [7:0] es, input logic [1:0] eio, input logic [1:0] ep, input logic [1:0] ebe,
		input int en);
		int n;
		int g;
		@(posedge mclk);
		vld <= 1'b1;
		req <= '{addr: a, write: w, size16: s16, kind: k};
		g = 0;
		@(negedge mclk);
		while (rdy !== 1'b1 && g < 20)
		begin
			@(negedge mclk);
			g++;
		end
		// a request never taken is a failure, not a silent skip
		if (g >= 20)
			num_errors++;
		@(posedge mclk);
		vld <= 1'b0;
		#1;
		chk(sel_n, es);
		chk({7'h0, addr_q === a}, 8'h01);
		chk({2'b00, io_n, rd_n, wr_n, be_n}, {2'b00, eio, ep, ebe});
		n = 0;
		while (done !== 1'b1 && n < 40)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk(8'(n), 8'(en));
		chk({7'h0, miss}, {7'h0, k == EBS_KIND_MEM && es == 8'hff});
	endtask : acc
	////////////////////////////////////////////////////////////////
	task t_reset;
		chk(sel_n, `EBS_BANK_SEL_IDLE);
		chk({2'b00, io_n, rd_n, wr_n, be_n}, 8'h3f);
	endtask : t_reset
	task t_sram;
		acc(24'h00_0010, 1'b0, 1'b1, EBS_KIND_MEM, 8'hfe, 2'h3, 2'b01, `EBS_LANES_IDLE, 2);
		acc(24'h00_0011, 1'b1, 1'b0, EBS_KIND_MEM, 8'hfe, 2'h3, 2'b10, `EBS_LANES_UPPER, 2);
		acc(24'h00_0010, 1'b1, 1'b0, EBS_KIND_MEM, 8'hfe, 2'h3, 2'b10, `EBS_LANES_LOWER, 2);
		acc(24'h00_0010, 1'b1, 1'b1, EBS_KIND_MEM, 8'hfe, 2'h3, 2'b10, `EBS_LANES_BOTH, 2);
		chk({7'h0, w16}, 8'h01);
	endtask : t_sram
	task t_sdram;
		acc(24'h20_0000, 1'b1, 1'b1, EBS_KIND_MEM, 8'hfb, 2'h3, 2'b10, `EBS_LANES_BOTH, 4);
		acc(24'h20_0001, 1'b0, 1'b0, EBS_KIND_MEM, 8'hfb, 2'h3, 2'b01, `EBS_LANES_UPPER, 4);
	endtask : t_sdram
	// x8 sram, rom, edo and flash: 16-bit write requests fire byte strobe zero only
	task t_nvm;
		for (int b = 1; b < 6; b++)
			if (b != 2)
				acc({4'(b), 20'h0}, 1'b1, 1'b1, EBS_KIND_MEM, ~(8'h01 << b), 2'h3, 2'b11, 2'b10, b + 2);
	endtask : t_nvm
	task t_narrow;
		acc(24'h60_0001, 1'b1, 1'b0, EBS_KIND_MEM, 8'hbf, 2'h3, 2'b10, `EBS_LANES_LOWER, 8);
		chk({7'h0, w16}, 8'h00);
	endtask : t_narrow
	task t_io;
		acc(24'h00_0000, 1'b0, 1'b1, EBS_KIND_IO0, 8'hff, 2'h2, 2'b01, `EBS_LANES_IDLE, 3);
		acc(24'h00_0000, 1'b1, 1'b1, EBS_KIND_IO1, 8'hff, 2'h1, 2'b10, `EBS_LANES_BOTH, 3);
	endtask : t_io
	// stall longer than the bank count: release waits for the device
	task t_wait;
		@(posedge mclk);
		wlen <= 4'h3;
		acc(24'h00_0000, 1'b0, 1'b1, EBS_KIND_MEM, 8'hfe, 2'h3, 2'b01, `EBS_LANES_IDLE, 4);
		@(posedge mclk);
		wlen <= 4'h0;
	endtask : t_wait
	task t_miss;
		acc(24'hf0_0000, 1'b0, 1'b1, EBS_KIND_MEM, 8'hff, 2'h3, 2'b11, `EBS_LANES_IDLE, 0);
	endtask : t_miss
	////////////////////////////////////////////////////////////////
	initial
	begin
		for (int i = 0; i < 8; i++)
		begin
			cfg[i].start_blk <= 8'(i * 16);
			cfg[i].end_blk <= 8'(i * 16 + 15);
			cfg[i].cycles <= 4'(i + 2);
			cfg[i].width16 <= (i != 1 && i != 6);
			cfg[i].mem <= (i < 6) ? ebs_mem_e'(3'(i)) : EBS_MEM_SRAM16;
		end
		repeat (3) @(posedge mclk);
		t_reset;
		rst <= 1'b0;
		t_sram;
		t_sdram;
		t_nvm;
		t_narrow;
		t_io;
		t_wait;
		t_miss;
		end_sim;
	end
	// cut a hang short well after the expected run length
	initial
	begin
		#100000;
		num_errors++;
		end_sim;
	end
endmodule : ebs_strobe_gen_tb
`default_nettype wire

// [hw/ebs_bank_decode.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ebs_params.svh"

module ebs_bank_decode
(
	// address and bank windows
	input wire logic [`EBS_ADDR_W-1:0] i_addr,
	input wire ebs_pkg::ebs_bank_cfg_s [`EBS_NUM_BANKS-1:0] i_bank_cfg,
	// decode result
	output logic [`EBS_NUM_BANKS-1:0] o_hit_onehot,
	output logic o_any_hit,
	output logic [2:0] o_hit_idx
);
	import ebs_pkg::*;

	logic [`EBS_NUM_BANKS-1:0] in_range;
	logic [7:0] blk;

	assign blk = i_addr[`EBS_BLK_HI:`EBS_BLK_LO];

	// window compare per bank, inclusive at both ends
	genvar g;
	generate
		for (g = 0; g < `EBS_NUM_BANKS; g = g + 1)
		begin : g_bank
			assign in_range[g] = (blk >= i_bank_cfg[g].start_blk) &&
				(blk <= i_bank_cfg[g].end_blk);
		end
	endgenerate

	// lowest bank wins so overlapping windows never raise two selects
	always_comb
	begin
		o_hit_onehot = '0;
		o_hit_idx = 3'h0;
		o_any_hit = 1'b0;
		for (int i = `EBS_NUM_BANKS - 1; i >= 0; i = i - 1)
		begin
			if (in_range[i])
			begin
				o_hit_onehot = '0;
				o_hit_onehot[i] = 1'b1;
				o_hit_idx = 3'(i);
				o_any_hit = 1'b1;
			end
		end
	end

endmodule : ebs_bank_decode

`default_nettype wire

// [hw/ebs_strobe_gen.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ebs_params.svh"

module ebs_strobe_gen
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	// bank and io configuration
	input wire ebs_pkg::ebs_bank_cfg_s [`EBS_NUM_BANKS-1:0] i_bank_config,
	input wire logic [`EBS_CYC_W-1:0] i_io_cycles,
	// access request from the core
	input wire logic i_req_valid,
	input wire ebs_pkg::ebs_req_s i_req,
	output logic o_req_ready,
	// completion
	output logic o_done,
	output logic o_miss,
	output logic o_bus_width16,
	// external bus pins
	input wire logic i_bus_wait_n,
	output logic [`EBS_ADDR_W-1:0] o_addr,
	output logic [`EBS_NUM_BANKS-1:0] o_bank_select_n,
	output logic [`EBS_NUM_IO-1:0] o_io_device_select_n,
	output logic o_read_strobe_n,
	output logic o_write_strobe_n,
	output logic [1:0] o_byte_write_strobe_n
);
	import ebs_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// decode

	logic [`EBS_NUM_BANKS-1:0] hit_onehot;
	logic any_hit;
	logic [2:0] hit_idx;
	logic take;
	logic is_io;
	logic [`EBS_CYC_W-1:0] cycles_sel;
	logic width16_sel;
	ebs_mem_e mem_sel;
	logic [1:0] lanes_n;
	logic [1:0] byte_n_nxt;
	logic we_n_nxt;
	logic oe_n_nxt;

	ebs_bank_decode u_decode
	(
		.i_addr(i_req.addr),
		.i_bank_cfg(i_bank_config),
		.o_hit_onehot(hit_onehot),
		.o_any_hit(any_hit),
		.o_hit_idx(hit_idx)
	);

	assign take = i_req_valid && o_req_ready;
	assign is_io = (i_req.kind != EBS_KIND_MEM);

	// per-target timing and width; io devices run 16-bit like x16 sram
	always_comb
	begin
		if (is_io)
		begin
			cycles_sel = i_io_cycles;
			width16_sel = 1'b1;
			mem_sel = EBS_MEM_SRAM16;
		end
		else
		begin
			cycles_sel = i_bank_config[hit_idx].cycles;
			width16_sel = i_bank_config[hit_idx].width16;
			mem_sel = i_bank_config[hit_idx].mem;
		end
	end

	// byte lanes: an 8-bit bus only ever uses the low lane
	always_comb
	begin
		if (!width16_sel)
			lanes_n = `EBS_LANES_LOWER;
		else if (i_req.size16)
			lanes_n = `EBS_LANES_BOTH;
		else if (i_req.addr[0])
			lanes_n = `EBS_LANES_UPPER;
		else
			lanes_n = `EBS_LANES_LOWER;
	end

	// strobe pattern per memory kind
	always_comb
	begin
		oe_n_nxt = 1'b1;
		we_n_nxt = 1'b1;
		byte_n_nxt = `EBS_LANES_IDLE;
		if (!i_req.write)
		begin
			oe_n_nxt = 1'b0;
			if (mem_sel == EBS_MEM_SDRAM)
				byte_n_nxt = lanes_n;
		end
		else
		begin
			case (mem_sel)
				EBS_MEM_SRAM16:
				begin
					we_n_nxt = 1'b0;
					byte_n_nxt = lanes_n;
				end
				EBS_MEM_SDRAM:
				begin
					we_n_nxt = 1'b0;
					byte_n_nxt = lanes_n;
				end
				// x8 sram, rom, edo and flash writes fire no write strobe; byte strobe zero still fires
				default:
				begin
					byte_n_nxt = `EBS_LANES_LOWER;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer

	ebs_state_e state_r;
	logic [`EBS_CYC_W-1:0] cnt_r;
	logic last_cycle;

	// wait is only looked at once the programmed count has run out
	assign last_cycle = (cnt_r <= `EBS_MIN_CYCLES) && i_bus_wait_n;

	// state transitions
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			state_r <= EBS_ST_IDLE;
		else
		begin
			case (state_r)
				EBS_ST_IDLE:
					if (take)
						state_r <= (is_io || any_hit) ? EBS_ST_STROBE : EBS_ST_DONE;
				EBS_ST_STROBE:
					if (last_cycle)
						state_r <= EBS_ST_DONE;
				EBS_ST_DONE:
					state_r <= EBS_ST_IDLE;
				default:
					state_r <= EBS_ST_IDLE;
			endcase
		end
	end

	// active cycle counter, a zero count is stretched to one cycle
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			cnt_r <= `EBS_MIN_CYCLES;
		else if (take)
			cnt_r <= (cycles_sel < `EBS_MIN_CYCLES) ? `EBS_MIN_CYCLES : cycles_sel;
		else if (state_r == EBS_ST_STROBE && cnt_r > `EBS_MIN_CYCLES)
			cnt_r <= cnt_r - `EBS_MIN_CYCLES;
	end

	// handshake and completion flags
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_req_ready <= 1'b0;
			o_done <= 1'b0;
			o_miss <= 1'b0;
		end
		else
		begin
			o_req_ready <= (state_r == EBS_ST_DONE) ||
				(state_r == EBS_ST_IDLE && !take);
			o_done <= (state_r == EBS_ST_STROBE && last_cycle) ||
				(take && !is_io && !any_hit);
			o_miss <= take && !is_io && !any_hit;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin drivers

	// address and width held for the whole access
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_addr <= '0;
			o_bus_width16 <= 1'b0;
		end
		else if (take)
		begin
			o_addr <= i_req.addr;
			o_bus_width16 <= width16_sel;
		end
	end

	// selects and strobes, released on the last active cycle
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_bank_select_n <= `EBS_BANK_SEL_IDLE;
			o_io_device_select_n <= `EBS_IO_SEL_IDLE;
			o_read_strobe_n <= 1'b1;
			o_write_strobe_n <= 1'b1;
			o_byte_write_strobe_n <= `EBS_LANES_IDLE;
		end
		else if (take && (is_io || any_hit))
		begin
			o_bank_select_n <= is_io ? `EBS_BANK_SEL_IDLE : ~hit_onehot;
			o_io_device_select_n <= {i_req.kind != EBS_KIND_IO1,
				i_req.kind != EBS_KIND_IO0};
			o_read_strobe_n <= oe_n_nxt;
			o_write_strobe_n <= we_n_nxt;
			o_byte_write_strobe_n <= byte_n_nxt;
		end
		else if (state_r != EBS_ST_STROBE || last_cycle)
		begin
			o_bank_select_n <= `EBS_BANK_SEL_IDLE;
			o_io_device_select_n <= `EBS_IO_SEL_IDLE;
			o_read_strobe_n <= 1'b1;
			o_write_strobe_n <= 1'b1;
			o_byte_write_strobe_n <= `EBS_LANES_IDLE;
		end
	end

endmodule : ebs_strobe_gen

`default_nettype wire

// [include/ebs_params.svh]
`ifndef EBS_PARAMS_SVH
`define EBS_PARAMS_SVH

// bus geometry
`define EBS_NUM_BANKS 8
`define EBS_NUM_IO 2
`define EBS_ADDR_W 24
`define EBS_CYC_W 4

// bank window compare uses the top address byte (64 KB blocks)
`define EBS_BLK_HI 23
`define EBS_BLK_LO 16

// idle (deasserted) pin levels, also the reset values
`define EBS_BANK_SEL_IDLE 8'hff
`define EBS_IO_SEL_IDLE 2'h3
`define EBS_LANES_IDLE 2'h3

// byte lane patterns, active low: bit1 upper byte, bit0 lower byte
`define EBS_LANES_BOTH 2'h0
`define EBS_LANES_UPPER 2'h1
`define EBS_LANES_LOWER 2'h2

// timing counts in clock cycles
`define EBS_MIN_CYCLES 4'h1
`define EBS_IO_CYCLES_RST 4'h2

`endif

// [include/ebs_pkg.sv]
`include "ebs_params.svh"

package ebs_pkg;

	// memory kinds a bank may hold
	typedef enum logic [2:0]
	{
		EBS_MEM_SRAM16 = 3'h0,
		EBS_MEM_SRAM8 = 3'h1,
		EBS_MEM_SDRAM = 3'h2,
		EBS_MEM_ROM = 3'h3,
		EBS_MEM_EDO = 3'h4,
		EBS_MEM_FLASH = 3'h5
	} ebs_mem_e;

	// target of an access
	typedef enum logic [1:0]
	{
		EBS_KIND_MEM = 2'h0,
		EBS_KIND_IO0 = 2'h1,
		EBS_KIND_IO1 = 2'h2
	} ebs_kind_e;

	// one-hot sequencer states
	typedef enum logic [2:0]
	{
		EBS_ST_IDLE = 3'b001,
		EBS_ST_STROBE = 3'b010,
		EBS_ST_DONE = 3'b100
	} ebs_state_e;

	// per-bank configuration
	typedef struct packed
	{
		logic [7:0] start_blk;
		logic [7:0] end_blk;
		logic [`EBS_CYC_W-1:0] cycles;
		logic width16;
		ebs_mem_e mem;
	} ebs_bank_cfg_s;

	// one access request
	typedef struct packed
	{
		logic [`EBS_ADDR_W-1:0] addr;
		logic write;
		logic size16;
		ebs_kind_e kind;
	} ebs_req_s;

endpackage : ebs_pkg
